// file: common/sms_pkg.sv
package sms_pkg;

	// Serial frame geometry
	localparam int         BYTE_W    = 8;
	localparam logic [2:0] CNT_RST   = 3'h0;
	localparam logic [2:0] OVR_BIT   = 3'h6;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	localparam logic [4:0] EDGE_RST  = 5'h00;
	localparam logic [4:0] EDGE_ONE  = 5'h01;
	localparam logic [4:0] EDGES     = 5'h10;

	// Master serial clock period in bus cycles, per rate select code
	localparam int PERIOD_DIV2   = 2;
	localparam int PERIOD_DIV8   = 8;
	localparam int PERIOD_DIV32  = 32;
	localparam int PERIOD_DIV128 = 128;

	// Half-period terminal counts for the divider counter
	localparam logic [5:0] HALF_DIV2   = 6'(PERIOD_DIV2 / 2 - 1);
	localparam logic [5:0] HALF_DIV8   = 6'(PERIOD_DIV8 / 2 - 1);
	localparam logic [5:0] HALF_DIV32  = 6'(PERIOD_DIV32 / 2 - 1);
	localparam logic [5:0] HALF_DIV128 = 6'(PERIOD_DIV128 / 2 - 1);
	localparam logic [5:0] DIV_RST     = 6'h00;

	// Reset values
	localparam logic [7:0] BYTE_RST     = 8'h00;
	localparam logic       TX_EMPTY_RST = 1'b1;
	localparam logic       FLAG_RST     = 1'b0;

	typedef enum logic [1:0] {
		SMS_IDLE = 2'b00,
		SMS_RUN  = 2'b01,
		SMS_TAIL = 2'b11
	} sms_state_t;

endpackage : sms_pkg

// file: rtl/sms_rate_gen.sv
`timescale 1ns/1ps
module sms_rate_gen (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       en,
	input  wire logic [1:0] sel,
	// Half-period strobe
	output logic            tick
);

	typedef struct packed {
		logic [5:0] cnt;
		logic       tick;
	} sms_div_t;

	sms_div_t s_r;
	sms_div_t s_nxt;
	logic [5:0] lim;

	always_comb begin
		case (sel)
			2'h0:    lim = sms_pkg::HALF_DIV2;
			2'h1:    lim = sms_pkg::HALF_DIV8;
			2'h2:    lim = sms_pkg::HALF_DIV32;
			default: lim = sms_pkg::HALF_DIV128;
		endcase
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		// Free running only while master and enabled
		if (!en) begin
			s_nxt.cnt = sms_pkg::DIV_RST;
		end else if (s_r.cnt >= lim) begin
			s_nxt.cnt = sms_pkg::DIV_RST;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule : sms_rate_gen

// file: rtl/sms_core.sv
`timescale 1ns/1ps
// Contract
// - Master select set gives master; clear gives slave with clock pin as input.
// - Only a master starts transfers; a data write launches one.
// - Write with shifter empty loads at once, sets tx empty, shifts out.
// - Two rate select bits set master clock generator driving the clock pin.
// - Shift in while shifting out; at end set rx full and load rx data.
// - Rx full clears on status read while set, then data read.
// - Any data write clears tx empty.
// - Slave copies complete byte to rx data and sets rx full.
// - Slave accepts any clock up to bus clock, ignoring rate select; here the pin is sampled once per bus cycle, so half bus clock at most.
// - Byte written to busy slave waits in buffer until transfer ends.
// - Slave start: phase set on first clock edge, else select fall.
// - Polarity bit selects active level of clock; four formats.
// - Slave drives its data output only while select is low.
// - Phase 0 slave drives MSB as soon as select falls.
// - Once slave transfer begins, no load into shifter until it ends.
// - Phase 1: first clock edge starts transfer; select may stay low.
// - Master periods 2, 8, 32, 128 bus cycles; start within one bit.
// - Overrun set if rx unread at bit 1 capture; byte then dropped.
module sms_core (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Configuration
	input  wire logic       block_enable_bit,
	input  wire logic       master_select_bit,
	input  wire logic       clk_pol,
	input  wire logic       clk_pha,
	input  wire logic       rate_select_high,
	input  wire logic       rate_select_low,
	// CPU access strobes
	input  wire logic       data_wr,
	input  wire logic [7:0] wr_data,
	input  wire logic       status_rd,
	input  wire logic       data_rd,
	// Status and receive data
	output logic [7:0]      rx_data,
	output logic            tx_empty_flag,
	output logic            rx_full_flag,
	output logic            overrun_flag,
	output logic            busy,
	// Serial clock pin
	input  wire logic       sck_i,
	output logic            sck_o,
	output logic            sck_oe,
	// Data pins
	input  wire logic       mosi_i,
	output logic            mosi_o,
	output logic            mosi_oe,
	input  wire logic       miso_i,
	output logic            miso_o,
	output logic            miso_oe,
	// Slave select, active low
	input  wire logic       ss_n_i
);

	typedef struct packed {
		sms_pkg::sms_state_t st;
		logic [7:0]          sr;
		logic                smp;
		logic [2:0]          cnt;
		logic [4:0]          tg;
		logic [7:0]          txbuf;
		logic                tx_empty;
		logic                loaded;
		logic [7:0]          rx_data;
		logic                rx_full;
		logic                ovr;
		logic                armed;
		logic                prev;
		logic                ss_prev;
		logic                mck;
		logic                miso_o;
		logic                miso_oe;
		logic                mosi_o;
		logic                mosi_oe;
		logic                sck_oe;
		logic                busy;
	} sms_core_t;

	sms_core_t s_r;
	sms_core_t s_nxt;

	logic tick;
	logic lvl;
	logic lead;
	logic trail;
	logic smp_e;
	logic sh_e;
	logic din;
	logic ss_fall;
	logic start;
	logic done;
	logic master;

	// Half-period strobe for the master clock
	sms_rate_gen sms_rate_gen_inst (
		.clk   (clk),
		.rst_n (rst_n),
		.en    (block_enable_bit & master_select_bit),
		.sel   ({rate_select_high, rate_select_low}),
		.tick  (tick)
	);

	always_comb begin
		s_nxt = s_r;
		master = master_select_bit;
		// Clock seen by the shifter: own clock as master, pin as slave
		lvl = master ? s_r.mck : sck_i;
		lead = (lvl != clk_pol) && (s_r.prev == clk_pol);
		trail = (lvl == clk_pol) && (s_r.prev != clk_pol);
		smp_e = clk_pha ? trail : lead;
		sh_e = clk_pha ? lead : trail;
		din = master ? miso_i : mosi_i;
		ss_fall = s_r.ss_prev & ~ss_n_i;
		start = 1'b0;
		done = 1'b0;
		s_nxt.prev = lvl;
		s_nxt.ss_prev = ss_n_i;

		// Status read with a flag up arms the clear; data read completes it
		if (status_rd && (s_r.rx_full || s_r.ovr)) begin
			s_nxt.armed = 1'b1;
		end
		if (data_rd && s_r.armed) begin
			s_nxt.rx_full = 1'b0;
			s_nxt.ovr = 1'b0;
			s_nxt.armed = 1'b0;
		end

		if (!block_enable_bit) begin
			s_nxt.st = sms_pkg::SMS_IDLE;
			s_nxt.cnt = sms_pkg::CNT_RST;
			s_nxt.tg = sms_pkg::EDGE_RST;
			s_nxt.loaded = 1'b0;
			s_nxt.mck = clk_pol;
		end else begin
			case (s_r.st)
				sms_pkg::SMS_IDLE: begin
					// A queued master byte is held until it has gone out
					if (!s_r.tx_empty && !(master && s_r.loaded)) begin
						s_nxt.sr = s_r.txbuf;
						s_nxt.tx_empty = 1'b1;
						s_nxt.loaded = 1'b1;
					end
					if (master) begin
						s_nxt.mck = clk_pol;
						if (s_r.loaded && tick) begin
							start = 1'b1;
							if (clk_pha) begin
								s_nxt.mck = ~clk_pol;
								s_nxt.tg = sms_pkg::EDGE_ONE;
							end else begin
								s_nxt.tg = sms_pkg::EDGE_RST;
							end
						end
					end else if (!ss_n_i && (clk_pha ? lead : ss_fall)) begin
						start = 1'b1;
					end
					if (start) begin
						s_nxt.st = sms_pkg::SMS_RUN;
						s_nxt.cnt = sms_pkg::CNT_RST;
						s_nxt.loaded = 1'b0;
					end
				end
				sms_pkg::SMS_RUN, sms_pkg::SMS_TAIL: begin
					// Master keeps toggling until all sixteen edges are out
					if (master && tick && s_r.tg != sms_pkg::EDGES) begin
						s_nxt.mck = ~s_r.mck;
						s_nxt.tg = s_r.tg + sms_pkg::EDGE_ONE;
					end
					if (s_r.st == sms_pkg::SMS_RUN) begin
						if (!master && ss_n_i) begin
							// Deselected mid-byte: abandon it
							s_nxt.st = sms_pkg::SMS_IDLE;
						end else if (smp_e) begin
							s_nxt.smp = din;
							s_nxt.cnt = s_r.cnt + 3'h1;
							if (s_r.cnt == sms_pkg::OVR_BIT && s_r.rx_full) begin
								s_nxt.ovr = 1'b1;
							end
							if (s_r.cnt == sms_pkg::LAST_BIT) begin
								done = 1'b1;
								s_nxt.sr = {s_r.sr[6:0], din};
							end
						end else if (sh_e && s_r.cnt != sms_pkg::CNT_RST) begin
							s_nxt.sr = {s_r.sr[6:0], s_r.smp};
						end
						if (done) begin
							s_nxt.st = master ? sms_pkg::SMS_TAIL
							                  : sms_pkg::SMS_IDLE;
							// Set wins over a clear in the same cycle
							if (!s_nxt.ovr) begin
								s_nxt.rx_data = {s_r.sr[6:0], din};
								s_nxt.rx_full = 1'b1;
							end
						end
					end else if (s_r.tg == sms_pkg::EDGES) begin
						s_nxt.st = sms_pkg::SMS_IDLE;
					end
				end
				default: begin
					s_nxt.st = sms_pkg::SMS_IDLE;
				end
			endcase
		end

		// Write during a transfer only fills the buffer; loads wait for idle
		if (data_wr) begin
			s_nxt.txbuf = wr_data;
			s_nxt.tx_empty = 1'b0;
		end

		s_nxt.miso_o = s_nxt.sr[7];
		s_nxt.miso_oe = block_enable_bit & ~master & ~ss_n_i;
		// Last bit holds one cycle past the last sampling edge so the far side gets it
		s_nxt.mosi_o = done ? s_r.mosi_o : s_nxt.sr[7];
		s_nxt.mosi_oe = block_enable_bit & master;
		s_nxt.sck_oe = block_enable_bit & master;
		s_nxt.busy = (s_nxt.st != sms_pkg::SMS_IDLE);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r          <= '0;
			s_r.st       <= sms_pkg::SMS_IDLE;
			s_r.sr       <= sms_pkg::BYTE_RST;
			s_r.txbuf    <= sms_pkg::BYTE_RST;
			s_r.rx_data  <= sms_pkg::BYTE_RST;
			s_r.tx_empty <= sms_pkg::TX_EMPTY_RST;
			s_r.rx_full  <= sms_pkg::FLAG_RST;
			s_r.ovr      <= sms_pkg::FLAG_RST;
			s_r.ss_prev  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_data       = s_r.rx_data;
	assign tx_empty_flag = s_r.tx_empty;
	assign rx_full_flag  = s_r.rx_full;
	assign overrun_flag  = s_r.ovr;
	assign busy          = s_r.busy;
	// Pin clock trails the internal one a cycle, so data moves clear of it
	assign sck_o         = s_r.prev;
	assign sck_oe        = s_r.sck_oe;
	assign mosi_o        = s_r.mosi_o;
	assign mosi_oe       = s_r.mosi_oe;
	assign miso_o        = s_r.miso_o;
	assign miso_oe       = s_r.miso_oe;

endmodule : sms_core

// file: verification/sms_core_monitor.sv
`timescale 1ns/1ps
module sms_core_monitor (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Controls
	input wire logic       block_enable_bit,
	input wire logic       master_select_bit,
	input wire logic       clk_pol,
	input wire logic       data_wr,
	input wire logic       data_rd,
	input wire logic       ss_n_i,
	// Status and pins
	input wire logic [7:0] rx_data,
	input wire logic       tx_empty_flag,
	input wire logic       rx_full_flag,
	input wire logic       overrun_flag,
	input wire logic       busy,
	input wire logic       sck_o,
	input wire logic       sck_oe,
	input wire logic       miso_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_launch;
		data_wr && sck_oe && !busy && tx_empty_flag;
	endsequence
	sequence s_frame;
		busy [*8];
	endsequence
	property p_wr_clr; data_wr |=> !tx_empty_flag; endproperty
	a_wr_clr: assert property (p_wr_clr)
		else $error("tx empty kept after write");
	property p_load; s_launch ##1 !data_wr |=> tx_empty_flag; endproperty
	a_load: assert property (p_load)
		else $error("idle load missing");
	property p_start; s_launch |-> ##[1:130] busy; endproperty
	a_start: assert property (p_start)
		else $error("master did not start");
	property p_reset; $rose(rst_n) |-> tx_empty_flag && !rx_full_flag; endproperty
	a_reset: assert property (p_reset)
		else $error("bad flags after reset");
	property p_rx_keep; rx_full_flag && !data_rd |=> rx_full_flag; endproperty
	a_rx_keep: assert property (p_rx_keep)
		else $error("rx full cleared without data read");
	property p_rx_load; $changed(rx_data) |-> $rose(rx_full_flag); endproperty
	a_rx_load: assert property (p_rx_load)
		else $error("rx data moved without rx full");
	property p_ovr;
		$rose(overrun_flag) |-> rx_full_flag && $stable(rx_data);
	endproperty
	a_ovr: assert property (p_ovr)
		else $error("overrun without unread byte");
	property p_miso;
		miso_oe |-> $past(block_enable_bit && !master_select_bit && !ss_n_i);
	endproperty
	a_miso: assert property (p_miso)
		else $error("miso driven while not selected");
	property p_sck_oe; sck_oe |-> $past(block_enable_bit && master_select_bit); endproperty
	a_sck_oe: assert property (p_sck_oe)
		else $error("clock driven outside master mode");
	property p_idle; !busy && sck_oe && $stable(clk_pol) |-> sck_o == clk_pol; endproperty
	a_idle: assert property (p_idle)
		else $error("clock not at idle level");
	property p_frame; $rose(busy) |-> s_frame; endproperty
	a_frame: assert property (p_frame)
		else $error("frame too short");
endmodule : sms_core_monitor
bind sms_core sms_core_monitor sms_core_monitor_inst (.clk(clk), .rst_n(rst_n),
	.block_enable_bit(block_enable_bit), .master_select_bit(master_select_bit),
	.clk_pol(clk_pol), .data_wr(data_wr), .data_rd(data_rd), .ss_n_i(ss_n_i),
	.rx_data(rx_data), .tx_empty_flag(tx_empty_flag),
	.rx_full_flag(rx_full_flag), .overrun_flag(overrun_flag), .busy(busy),
	.sck_o(sck_o), .sck_oe(sck_oe), .miso_oe(miso_oe));

// file: verification/sms_peer.sv
`timescale 1ns/1ps
module sms_peer (
	// Bus clock and role
	input  wire logic clk,
	input  wire logic mst,
	input  wire logic pol,
	input  wire logic pha,
	// Resolved lines
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic miso,
	// Lines driven by the peer
	output logic      p_sck,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss_n
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	logic [2:0] c = 3'h0;
	logic       fr = 1'b0, ss = 1'b1, sk = 1'b0, mo = 1'b0;
	// Released data lines toggle every half cycle, following the inverted bus clock, so no stale value passes; released clock sits at pol
	assign p_sck  = fr ? sk : pol;
	assign p_mosi = fr ? mo : ~clk;
	assign p_miso = mst ? ~clk : tx[3'h7 + {2'h0, pha} - c];
	assign p_ss_n = ss;
	always @(posedge sck or negedge sck) begin
		if (!mst) begin
			if ((sck != pol) ^ pha) rx <= {rx[6:0], mosi};
			else c <= c + 3'h1;
		end
	end
	task arm(input logic [7:0] b);
		tx = b;
		c = 3'h0;
	endtask : arm
	task send(input logic [7:0] b);
		@(negedge clk);
		sk = pol;
		fr = 1'b1;
		ss = 1'b0;
		mo = b[7];
		repeat (4) @(negedge clk);
		for (int i = 7; i >= 0; i--) begin
			sk = ~pol;
			if (pha) mo = b[i];
			else rx = {rx[6:0], miso};
			repeat (4) @(negedge clk);
			sk = pol;
			if (pha) rx = {rx[6:0], miso};
			else if (i > 0) mo = b[i-1];
			repeat (4) @(negedge clk);
		end
		ss = 1'b1;
		fr = 1'b0;
	endtask : send
endmodule : sms_peer

// file: verification/sms_core_test.sv
`timescale 1ns/1ps
module sms_core_test;
	logic       clk = 1'b0, rst_n = 1'b0;
	logic       en = 1'b0, msel = 1'b1, pol = 1'b0, pha = 1'b0;
	logic       rh = 1'b0, rl = 1'b0, wr = 1'b0, srd = 1'b0, drd = 1'b0;
	logic [7:0] wd = 8'h00, rx_data;
	logic       txe, rxf, ovr, busy, sck_o, sck_oe, mosi_o, mosi_oe;
	logic       miso_o, miso_oe, sck, mosi, miso, p_sck, p_mosi, p_miso, p_ss_n;
	int         bad_count = 0, compares = 0, cycles = 0;
	assign sck  = sck_oe ? sck_o : p_sck;
	assign mosi = mosi_oe ? mosi_o : p_mosi;
	assign miso = miso_oe ? miso_o : p_miso;
	sms_core sms_core_inst (.clk(clk), .rst_n(rst_n), .block_enable_bit(en),
		.master_select_bit(msel), .clk_pol(pol), .clk_pha(pha),
		.rate_select_high(rh), .rate_select_low(rl), .data_wr(wr), .wr_data(wd),
		.status_rd(srd), .data_rd(drd), .rx_data(rx_data), .tx_empty_flag(txe),
		.rx_full_flag(rxf), .overrun_flag(ovr), .busy(busy), .sck_i(sck),
		.sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o), .miso_oe(miso_oe),
		.ss_n_i(p_ss_n));
	sms_peer sms_peer_inst (.clk(clk), .mst(!msel), .pol(pol), .pha(pha),
		.sck(sck), .mosi(mosi), .miso(miso), .p_sck(p_sck), .p_mosi(p_mosi),
		.p_miso(p_miso), .p_ss_n(p_ss_n));
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	task check(input string nm, input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task chk1(input string nm, input logic got, exp);
		check(nm, {7'h00, got}, {7'h00, exp});
	endtask : chk1
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task setup(input logic m, ph, po, input logic [1:0] r);
		en = 1'b0;
		cyc(1);
		// Format changes only while disabled
		{msel, pha, pol, rh, rl} = {m, ph, po, r};
		cyc(1);
		en = 1'b1;
		cyc(2);
	endtask : setup
	task wr_byte(input logic [7:0] b);
		wr = 1'b1;
		wd = b;
		cyc(1);
		wr = 1'b0;
		chk1("tx_empty", txe, 1'b0);
	endtask : wr_byte
	task rd_both;
		srd = 1'b1;
		cyc(1);
		srd = 1'b0;
		drd = 1'b1;
		cyc(1);
		drd = 1'b0;
	endtask : rd_both
	task automatic idle_wait;
		int n = 0;
		int k = 0;
		while (k < 140 && n < 5000) begin
			cyc(1);
			n++;
			k = busy ? 0 : k + 1;
		end
	endtask : idle_wait
	task complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial begin
		cyc(10);
		rst_n = 1'b1;
		cyc(2);
		chk1("tx_empty", txe, 1'b1);
		chk1("rx_full", rxf, 1'b0);
		chk1("busy", busy, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			setup(1'b1, i[1], i[0], 2'(i));
			sms_peer_inst.arm(8'h3C + 8'(i));
			wr_byte(8'hA5 ^ 8'(i));
			idle_wait();
			check("rx_data", rx_data, 8'h3C + 8'(i));
			check("peer_rx", sms_peer_inst.rx, 8'hA5 ^ 8'(i));
			drd = 1'b1;
			cyc(1);
			drd = 1'b0;
			chk1("rx_full", rxf, 1'b1);
			rd_both();
			chk1("rx_full", rxf, 1'b0);
		end
		$display("test master done");
		setup(1'b1, 1'b0, 1'b0, 2'h0);
		sms_peer_inst.arm(8'h5E);
		// Writes on two consecutive edges: the second queues behind the first
		wr = 1'b1;
		wd = 8'h11;
		cyc(1);
		chk1("tx_empty", txe, 1'b0);
		wd = 8'h22;
		cyc(1);
		wr = 1'b0;
		chk1("tx_empty", txe, 1'b0);
		idle_wait();
		chk1("overrun", ovr, 1'b1);
		check("rx_data", rx_data, 8'h5E);
		check("peer_rx", sms_peer_inst.rx, 8'h22);
		rd_both();
		chk1("overrun", ovr, 1'b0);
		$display("test overrun done");
		for (int j = 0; j < 2; j++) begin
			setup(1'b0, j[0], !j[0], 2'h3);
			wr_byte(8'hC3 ^ 8'(j));
			cyc(2);
			chk1("miso_oe", miso_oe, 1'b0);
			sms_peer_inst.send(8'h5A ^ 8'(j));
			cyc(4);
			check("rx_data", rx_data, 8'h5A ^ 8'(j));
			check("peer_rx", sms_peer_inst.rx, 8'hC3 ^ 8'(j));
			chk1("rx_full", rxf, 1'b1);
			rd_both();
		end
		$display("test slave done");
		complete_run();
	end
endmodule : sms_core_test
